// *** rtl/astx_baud.sv ***
// baud divider producing a one-cycle bit tick
`timescale 1ns/1ps
module astx_baud #(
  parameter logic [15:0] DIV = astx_pkg::BAUD_DIV
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic reset_n,  // async reset, low
  input  wire logic run,      // count while high
  input  wire logic restart,  // realign phase
  output logic      tick      // one-cycle bit tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } astx_baud_st_t;
  astx_baud_st_t s_reg;
  astx_baud_st_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (restart) begin
      // start bit counts its first cycle at once
      s_next.cnt = 16'h0001;
    end else if (!run) begin
      s_next.cnt = 16'h0000;
    end else if (s_reg.cnt >= DIV - 16'h0001) begin
      s_next.cnt  = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule

// *** rtl/astx_if.sv ***
// serial line between the transmitter and the remote receiver
`timescale 1ns/1ps
interface astx_if;
  logic tx_line;     // serial data, idles high
  logic tx_line_oe;  // transmitter drives the pin
  modport dev (output tx_line, output tx_line_oe);
  modport far (input tx_line, input tx_line_oe);
endinterface

// *** rtl/astx_pkg.sv ***
// shared constants for the asynchronous serial transmitter and its receiver
package astx_pkg;
  localparam int          DATA_W           = 8;
  localparam int          CHAR_W           = 9;
  localparam int          BITCNT_W         = 4;
  localparam logic [3:0]  BITS_8           = 4'h8;
  localparam logic [3:0]  BITS_9           = 4'h9;
  localparam logic        LINE_IDLE        = 1'b1;
  localparam logic        START_LEVEL      = 1'b0;
  localparam logic        STOP_LEVEL       = 1'b1;
  localparam logic [1:0]  FLAG_DELAY       = 2'h2;
  localparam logic [15:0] BAUD_DIV         = 16'h0010;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_DATA         = 8'h08;
  localparam int          CTRL_TX_EN       = 0;
  localparam int          CTRL_PORTEN      = 1;
  localparam int          CTRL_SYNC        = 2;
  localparam int          CTRL_NINE        = 3;
  localparam int          CTRL_NINTHD      = 4;
  localparam int          CTRL_TX_IRQ_EN   = 5;
  localparam int          CTRL_GLOBAL_IRQ  = 6;
  localparam int          CTRL_PERIPH_IRQ  = 7;
  localparam int          STAT_EMPTY       = 0;
  localparam int          STAT_SHIFT_EMPTY = 1;
  localparam int          STAT_RXVAL       = 2;
  localparam int          STAT_FRERR       = 3;
endpackage

// *** rtl/astx_rx.sv ***
// remote receiver end: samples the line mid-bit and reports characters
`timescale 1ns/1ps
module astx_rx #(
  parameter logic [15:0] BAUD_DIV = astx_pkg::BAUD_DIV
) (
  input  wire logic       clk_sys,   // system clock
  input  wire logic       reset_n,   // async reset, low
  input  wire logic       nine_bit,  // expect nine data bits
  output logic      [8:0] rx_data,   // last character
  output logic            rx_valid,  // one-cycle pulse per char
  output logic            rx_ferr,   // stop bit was low
  astx_if.far             line       // serial line
);
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_BITS = 3'b010,
    RS_STOP = 3'b100
  } astx_rx_state_t;

  typedef struct packed {
    astx_rx_state_t state;
    logic [15:0]    cnt;
    logic [3:0]     left;
    logic [8:0]     sh;
    logic [8:0]     data;
    logic           valid;
    logic           ferr;
  } astx_rx_st_t;

  astx_rx_st_t s_reg;
  astx_rx_st_t s_next;
  logic        bit_in;
  logic        mid;

  assign bit_in = line.tx_line_oe ? line.tx_line : astx_pkg::LINE_IDLE;
  assign mid    = s_reg.cnt == BAUD_DIV - 16'h0001;

  always_comb begin
    s_next       = s_reg;
    s_next.valid = 1'b0;
    s_next.cnt   = mid ? 16'h0000 : s_reg.cnt + 16'h0001;
    case (s_reg.state)
      RS_IDLE: begin
        s_next.cnt = {1'b0, BAUD_DIV[15:1]};
        if (bit_in == astx_pkg::START_LEVEL) begin
          s_next.state = RS_BITS;
          // start bit is sampled too, then shifted out
          s_next.left  = (nine_bit ? astx_pkg::BITS_9 : astx_pkg::BITS_8)
                       + 4'h1;
          s_next.sh    = 9'h000;
        end
      end
      RS_BITS: begin
        if (mid) begin
          s_next.sh   = {bit_in, s_reg.sh[8:1]};
          s_next.left = s_reg.left - 4'h1;
          if (s_reg.left == 4'h1) begin
            s_next.state = RS_STOP;
          end
        end
      end
      RS_STOP: begin
        if (mid) begin
          s_next.state = RS_IDLE;
          s_next.data  = nine_bit ? s_reg.sh : {1'b0, s_reg.sh[8:1]};
          s_next.valid = 1'b1;
          s_next.ferr  = bit_in != astx_pkg::STOP_LEVEL;
        end
      end
      default: begin
        s_next.state = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg       <= '0;
      s_reg.state <= RS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rx_data  = s_reg.data;
  assign rx_valid = s_reg.valid;
  assign rx_ferr  = s_reg.ferr;
endmodule

// *** rtl/astx_tx.sv ***
// asynchronous serial transmitter with holding buffer and shift register
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module astx_tx #(
  parameter logic [15:0] BAUD_DIV = astx_pkg::BAUD_DIV
) (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       reset_n,  // async reset, low
  input  wire logic [7:0] addr,     // register address
  input  wire logic [7:0] wdata,    // write data
  input  wire logic       wr,       // write strobe
  input  wire logic       rd,       // read strobe
  output logic      [7:0] rdata,    // read data, cycle after rd
  output logic            irq,      // transmit interrupt request
  astx_if.dev             line      // serial line
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_SHIFT = 3'b100
  } astx_tx_state_t;

  typedef struct packed {
    astx_tx_state_t state;
    logic [7:0]     ctrl;
    logic [7:0]     hold;
    logic           hold_full;
    logic [8:0]     shreg;
    logic [3:0]     bits_left;
    logic [3:0]     char_bits;
    logic           flag;
    logic [1:0]     wr_age;
    logic           line_q;
    logic           oe_q;
    logic           irq_q;
    logic [7:0]     rdata;
  } astx_tx_st_t;

  astx_tx_st_t s_reg;
  astx_tx_st_t s_next;
  logic        tick;
  logic        active;
  logic        load;
  logic        baud_run;

  // ----------------------------------------------------------------
  // enables and bit timing
  // ----------------------------------------------------------------
  assign active = s_reg.ctrl[astx_pkg::CTRL_TX_EN]
                & s_reg.ctrl[astx_pkg::CTRL_PORTEN]
                & ~s_reg.ctrl[astx_pkg::CTRL_SYNC];
  assign baud_run = s_reg.state != ST_IDLE;

  astx_baud #(
    .DIV     (BAUD_DIV)
  ) i_astx_baud (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (baud_run),
    .restart (load),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    load   = 1'b0;
    if (wr && addr == astx_pkg::REG_CTRL) begin
      s_next.ctrl = wdata;
    end
    // only the holding buffer is writable; shifter has no address
    if (wr && addr == astx_pkg::REG_DATA && active) begin
      s_next.hold      = wdata;
      s_next.hold_full = 1'b1;
      s_next.wr_age    = 2'h0;
    end else if (s_reg.wr_age != astx_pkg::FLAG_DELAY) begin
      s_next.wr_age = s_reg.wr_age + 2'h1;
    end
    // shifter sequencing
    case (s_reg.state)
      ST_IDLE: begin
        if (s_reg.hold_full && active) begin
          load = 1'b1;
        end
      end
      ST_START: begin
        if (tick) begin
          s_next.state = ST_SHIFT;
          s_next.line_q = s_reg.shreg[0];
          s_next.shreg  = {astx_pkg::STOP_LEVEL, s_reg.shreg[8:1]};
          s_next.bits_left = s_reg.char_bits;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          if (s_reg.bits_left == 4'h0) begin
            // stop bit done: next char loads in this same cycle
            if (s_reg.hold_full && active) begin
              load = 1'b1;
            end else begin
              s_next.state  = ST_IDLE;
              s_next.line_q = astx_pkg::LINE_IDLE;
            end
          end else begin
            s_next.line_q = s_reg.bits_left == 4'h1
                          ? astx_pkg::STOP_LEVEL : s_reg.shreg[0];
            s_next.shreg  = {astx_pkg::STOP_LEVEL, s_reg.shreg[8:1]};
            s_next.bits_left = s_reg.bits_left - 4'h1;
          end
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    if (load) begin
      s_next.state     = ST_START;
      s_next.line_q    = astx_pkg::START_LEVEL;
      s_next.shreg     = {s_reg.ctrl[astx_pkg::CTRL_NINTHD],
                          s_reg.hold};
      s_next.char_bits = s_reg.ctrl[astx_pkg::CTRL_NINE]
                       ? astx_pkg::BITS_9 : astx_pkg::BITS_8;
      if (!(wr && addr == astx_pkg::REG_DATA && active)) begin
        s_next.hold_full = 1'b0;
      end
    end
    if (!active) begin
      s_next.hold_full = 1'b0;
      s_next.state     = ST_IDLE;
      s_next.line_q    = astx_pkg::LINE_IDLE;
    end
    // pin released: line back to idle together with its enable
    if (!s_next.ctrl[astx_pkg::CTRL_PORTEN]) begin
      s_next.line_q = astx_pkg::LINE_IDLE;
    end
    // flag follows buffer state, updated once the write has aged
    if (s_next.wr_age == astx_pkg::FLAG_DELAY || !s_next.hold_full) begin
      s_next.flag = active & ~s_next.hold_full;
    end
    if (s_next.wr_age != astx_pkg::FLAG_DELAY && s_next.hold_full) begin
      s_next.flag = s_reg.flag & active;
    end
    s_next.irq_q = s_next.flag
                 & s_next.ctrl[astx_pkg::CTRL_TX_IRQ_EN]
                 & s_next.ctrl[astx_pkg::CTRL_GLOBAL_IRQ]
                 & s_next.ctrl[astx_pkg::CTRL_PERIPH_IRQ];
    s_next.oe_q  = s_next.ctrl[astx_pkg::CTRL_PORTEN];
    // read data stand one cycle after the strobe, zero otherwise
    s_next.rdata = 8'h00;
    if (rd) begin
      case (addr)
        astx_pkg::REG_CTRL: s_next.rdata = s_reg.ctrl;
        astx_pkg::REG_STATUS: begin
          s_next.rdata[astx_pkg::STAT_EMPTY] = s_reg.flag;
          s_next.rdata[astx_pkg::STAT_SHIFT_EMPTY] =
            s_reg.state == ST_IDLE;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_reg        <= '0;
      s_reg.state  <= ST_IDLE;
      s_reg.line_q <= astx_pkg::LINE_IDLE;
      s_reg.wr_age <= astx_pkg::FLAG_DELAY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata           = s_reg.rdata;
  assign irq             = s_reg.irq_q;
  assign line.tx_line    = s_reg.line_q;
  assign line.tx_line_oe = s_reg.oe_q;
endmodule

// *** sim/astx_monitor.sv ***
// line checks between the transmitter and the remote receiver
`timescale 1ns/1ps
module astx_monitor #(
  parameter int DIV = 4
) (
  input wire logic clk_sys,    // system clock
  input wire logic reset_n,    // async reset, low
  input wire logic tx_line,    // serial data
  input wire logic tx_line_oe  // transmitter drives pin
);
  logic [7:0] run_reg;
  logic       last_reg;

  // cycles since the line last changed level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_reg  <= 8'h00;
      last_reg <= 1'b1;
    end else begin
      last_reg <= tx_line;
      if (tx_line != last_reg) begin
        run_reg <= 8'h00;
      end else if (run_reg != 8'hff) begin
        run_reg <= run_reg + 8'h01;
      end
    end
  end

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence level_change_s;
    tx_line != last_reg;
  endsequence

  sequence line_rise_s;
    tx_line && !last_reg;
  endsequence

  sequence low_held_s;
    !tx_line && !last_reg;
  endsequence

  idle_high_a: assert property (!tx_line_oe |-> tx_line)
    else $error("line low while undriven");
  bit_width_a: assert property (
    level_change_s |-> run_reg >= DIV - 1)
    else $error("bit too short");
  stop_seen_a: assert property (
    low_held_s |-> run_reg < 10 * DIV)
    else $error("no stop bit");
  start_driven_a: assert property ($fell(tx_line) |-> tx_line_oe)
    else $error("start without drive");
  bit_multiple_a: assert property (
    line_rise_s |-> (run_reg + 8'h01) % DIV == 0)
    else $error("low run not whole bits");
  oe_quiet_a: assert property ($changed(tx_line_oe) |-> tx_line)
    else $error("enable moved while line low");
endmodule

// *** sim/tb.sv ***
// self-checking bench for transmitter and remote receiver
`timescale 1ns/1ps
module tb;
  localparam int DIV = 4;
  logic        clk_sys;
  logic        reset_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  b;
  logic        wr;
  logic        rd;
  logic        rd_q;
  logic        irq;
  logic        nine;
  logic [8:0]  rx_data;
  logic        rx_valid;
  logic        rx_ferr;
  int          n_errors;
  int          check_count;
  int          i;
  logic [8:0]  exp_rx[$];
  logic [15:0] exp_rd[$];

  astx_if line_bus();
  astx_tx #(.BAUD_DIV(16'(DIV))) i_astx_tx (.clk_sys(clk_sys),
    .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .line(line_bus.dev));
  astx_rx #(.BAUD_DIV(16'(DIV))) i_astx_rx (.clk_sys(clk_sys),
    .reset_n(reset_n), .nine_bit(nine), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ferr(rx_ferr), .line(line_bus.far));
  astx_monitor #(.DIV(DIV)) i_astx_monitor (.clk_sys(clk_sys),
    .reset_n(reset_n), .tx_line(line_bus.tx_line),
    .tx_line_oe(line_bus.tx_line_oe));

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // mask, expected value
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    exp_rd.push_back({m, e});
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  task automatic send(input logic [8:0] c);
    exp_rx.push_back(c);
    wr_reg(astx_pkg::REG_DATA, c[7:0]);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 3000 && exp_rx.size() > 0; k++) @(posedge clk_sys);
    if (exp_rx.size() > 0) begin
      n_errors++;
      final_report();
    end
    repeat (3 * DIV) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // watcher
  // ------------------------------------------------------------
  always @(posedge clk_sys) rd_q <= rd;

  always @(negedge clk_sys) begin
    if (rd_q === 1'b1) begin
      chk({1'b0, rdata & exp_rd[0][15:8]}, {1'b0, exp_rd[0][7:0]});
      void'(exp_rd.pop_front());
    end
    if (rx_valid === 1'b1) begin
      chk(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : ~rx_data);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rd_q = 1'b0;
    nine = 1'b0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'h27e1));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h02);
    rd_reg(8'h0c, 8'hff, 8'h00);
    wr_reg(astx_pkg::REG_CTRL, 8'h03);
    rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h03);
    wr_reg(astx_pkg::REG_STATUS, 8'h00);
    rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h03);
    wr_reg(astx_pkg::REG_CTRL, 8'he3);
    repeat (2) @(posedge clk_sys);
    chk({8'h00, irq}, 9'h001);
    wr_reg(astx_pkg::REG_CTRL, 8'h63);
    repeat (2) @(posedge clk_sys);
    chk({8'h00, irq}, 9'h000);
    rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h03);
    for (i = 0; i < 3; i++) begin
      b = 8'($urandom);
      send({1'b0, b});
      send({1'b0, ~b});
      // flag settles two cycles after the queued write
      repeat (2) @(posedge clk_sys);
      rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h00);
      drain();
      rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h03);
    end
    nine <= 1'b1;
    for (i = 0; i < 4; i++) begin
      b = 8'($urandom);
      wr_reg(astx_pkg::REG_CTRL, i[0] ? 8'h1b : 8'h0b);
      send({i[0], b});
      drain();
    end
    nine <= 1'b0;
    wr_reg(astx_pkg::REG_CTRL, 8'h07);
    rd_reg(astx_pkg::REG_STATUS, 8'h03, 8'h02);
    wr_reg(astx_pkg::REG_CTRL, 8'h01);
    wr_reg(astx_pkg::REG_DATA, 8'h5a);
    repeat (12 * DIV) @(posedge clk_sys);
    chk({7'h00, line_bus.tx_line_oe, line_bus.tx_line}, 9'h001);
    chk({8'h00, rx_ferr}, 9'h000);
    final_report();
  end
endmodule
